// ==== common/dtb_pkg.sv ====
// Package for the delay trigger block: register map, field layout,
// reset values, timing counts and the converter carrier types.
// Assumes a 32-bit APB slave on a single 20 MHz clock.
package dtb_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] DTB_OFF_CTRL = 8'h00;
  localparam logic [7:0] DTB_OFF_DELAY_A = 8'h04;
  localparam logic [7:0] DTB_OFF_DELAY_B = 8'h08;
  localparam logic [7:0] DTB_OFF_CONV_CTL = 8'h0C;
  localparam logic [7:0] DTB_OFF_CONV_RES = 8'h1C;
  localparam logic [7:0] DTB_OFF_FLT_CFG = 8'h2C;
  localparam logic [7:0] DTB_OFF_STATUS = 8'h30;
  localparam logic [7:0] DTB_OFF_IRQ_STAT = 8'h34;
  localparam logic [7:0] DTB_OFF_IRQ_EN = 8'h38;
  localparam logic [7:0] DTB_OFF_IRQ_CLR = 8'h3C;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int DTB_CTRL_EN_BIT = 0;
  localparam int DTB_CTRL_GAIN_BIT = 1;
  localparam int DTB_CHAN_W = 5;
  localparam int DTB_CTL_IE_BIT = 6;
  localparam int DTB_RES_W = 12;
  localparam int DTB_CNT_W = 16;
  localparam int DTB_FLT_PER_LSB = 0;
  localparam int DTB_FLT_NUM_LSB = 8;
  localparam int DTB_IRQ_W = 4;
  localparam int DTB_IRQ_CONV = 0;
  localparam int DTB_IRQ_FAULT = 1;
  localparam int DTB_IRQ_TRIG_A = 2;
  localparam int DTB_IRQ_TRIG_B = 3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [1:0] DTB_CTRL_RST = 2'h0;
  localparam logic [15:0] DTB_DELAY_A_RST = 16'h0660;
  localparam logic [15:0] DTB_DELAY_B_RST = 16'h06D6;
  localparam logic [7:0] DTB_FLT_PER_RST = 8'h00;
  localparam logic [3:0] DTB_FLT_NUM_RST = 4'h3;
  localparam logic [15:0] DTB_CNT_MAX = 16'hFFFF;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int DTB_ADC_DIV = 4;
  localparam logic [1:0] DTB_ADC_DIV_LAST = 2'(DTB_ADC_DIV - 1);

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic start;
    logic slot_b;
    logic [DTB_CHAN_W-1:0] chan;
  } dtb_cmd_type;

  typedef struct packed {
    logic done;
    logic [DTB_RES_W-1:0] data;
  } dtb_res_type;

  typedef struct packed {
    logic ie;
    logic [DTB_CHAN_W-1:0] chan;
  } dtb_ctl_type;

endpackage

// ==== core/dtb_sequencer.sv ====
// Delay trigger block: sync-started delay counter, ping-pong trigger
// sequencing of two converters, result registers, fault input filter
// and interrupt logic, reached over APB.
// Assumes converter done/data come from logic on pclk; sync and fault
// arrive from pins and are synchronised here.
`timescale 1ns/1ps

module dtb_sequencer
  import dtb_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic pwm_sync,
  input wire logic fault_pin,
  output logic fault_out,
  output logic irq,
  // Converters
  output dtb_pkg::dtb_cmd_type conv0_cmd,
  output dtb_pkg::dtb_cmd_type conv1_cmd,
  output logic adc_clk_en,
  input wire dtb_pkg::dtb_res_type conv0_res,
  input wire dtb_pkg::dtb_res_type conv1_res
);
  import dtb_pkg::*;

  // ************************************************************
  // Registers and state
  // ************************************************************
  logic [1:0] ctrl_q;
  logic [DTB_CNT_W-1:0] delay_a_q, delay_b_q, cnt_q;
  dtb_ctl_type ctl_q [4];
  logic [DTB_RES_W-1:0] res_q [4];
  logic [7:0] flt_per_q, flt_div_q;
  logic [3:0] flt_num_q, agree_q;
  logic [DTB_IRQ_W-1:0] stat_q, en_q;
  logic [1:0] cc_q, busy_q, slot_q;
  logic running_q, a_done_q, b_done_q, b_pend_q;
  logic sync_s1, sync_s2, sync_s3, flt_s1, flt_s2;
  logic [31:0] rd_mux;
  logic hit;
  logic [1:0] adc_div_q;

  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire sync_rise = sync_s2 & ~sync_s3;
  wire armed = ctrl_q[DTB_CTRL_EN_BIT] & ~ctrl_q[DTB_CTRL_GAIN_BIT];
  wire trig_a = armed & running_q & ~a_done_q & (cnt_q == delay_a_q);
  wire hit_b = armed & running_q & ~b_done_q & (cnt_q == delay_b_q);
  // An idle pair launches in the matching cycle, like the first trigger
  wire launch_b = (b_pend_q | hit_b) & (busy_q == 2'b00);
  // Each converter's flag is cleared only by a read of its own results
  wire [1:0] rd_res = {2{rd}} & {(paddr >= DTB_OFF_CONV_RES + 8'h08) &
                                 (paddr < DTB_OFF_CONV_RES + 8'h10),
                                 (paddr >= DTB_OFF_CONV_RES) &
                                 (paddr < DTB_OFF_CONV_RES + 8'h08)};
  wire [DTB_IRQ_W-1:0] ev = {launch_b, trig_a, 1'b0,
                             conv0_res.done & ~slot_q[0] & ctl_q[0].ie};

  // ************************************************************
  // APB slave
  // ************************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      DTB_OFF_CTRL: rd_mux = {30'h0, ctrl_q};
      DTB_OFF_DELAY_A: rd_mux = {16'h0, delay_a_q};
      DTB_OFF_DELAY_B: rd_mux = {16'h0, delay_b_q};
      DTB_OFF_CONV_CTL: rd_mux = {25'h0, ctl_q[0].ie, 1'b0, ctl_q[0].chan};
      DTB_OFF_CONV_CTL + 8'h04: rd_mux = {25'h0, ctl_q[1].ie, 1'b0, ctl_q[1].chan};
      DTB_OFF_CONV_CTL + 8'h08: rd_mux = {25'h0, ctl_q[2].ie, 1'b0, ctl_q[2].chan};
      DTB_OFF_CONV_CTL + 8'h0C: rd_mux = {25'h0, ctl_q[3].ie, 1'b0, ctl_q[3].chan};
      DTB_OFF_CONV_RES: rd_mux = {20'h0, res_q[0]};
      DTB_OFF_CONV_RES + 8'h04: rd_mux = {20'h0, res_q[1]};
      DTB_OFF_CONV_RES + 8'h08: rd_mux = {20'h0, res_q[2]};
      DTB_OFF_CONV_RES + 8'h0C: rd_mux = {20'h0, res_q[3]};
      DTB_OFF_FLT_CFG: rd_mux = {20'h0, flt_num_q, flt_per_q};
      DTB_OFF_STATUS: rd_mux = {cnt_q, 11'h0, running_q, fault_out, b_pend_q, cc_q};
      DTB_OFF_IRQ_STAT: rd_mux = {28'h0, stat_q};
      DTB_OFF_IRQ_EN: rd_mux = {28'h0, en_q};
      DTB_OFF_IRQ_CLR: rd_mux = 32'h0000_0000;
      default: hit = 1'b0;
    endcase
  end

  // One access cycle: ready rises the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= setup & ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= DTB_CTRL_RST;
      delay_a_q <= DTB_DELAY_A_RST;
      delay_b_q <= DTB_DELAY_B_RST;
      flt_per_q <= DTB_FLT_PER_RST;
      flt_num_q <= DTB_FLT_NUM_RST;
      en_q <= '0;
      for (int i = 0; i < 4; i++) begin
        ctl_q[i] <= '0;
      end
    end else if (wr && !pslverr) begin
      case (paddr)
        DTB_OFF_CTRL: ctrl_q <= pwdata[1:0];
        DTB_OFF_DELAY_A: delay_a_q <= pwdata[15:0];
        DTB_OFF_DELAY_B: delay_b_q <= pwdata[15:0];
        DTB_OFF_FLT_CFG: begin
          flt_per_q <= pwdata[DTB_FLT_PER_LSB +: 8];
          flt_num_q <= pwdata[DTB_FLT_NUM_LSB +: 4];
        end
        DTB_OFF_IRQ_EN: en_q <= pwdata[DTB_IRQ_W-1:0];
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (paddr == DTB_OFF_CONV_CTL + 8'(4 * i)) begin
              ctl_q[i].ie <= pwdata[DTB_CTL_IE_BIT];
              ctl_q[i].chan <= pwdata[DTB_CHAN_W-1:0];
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
      flt_s1 <= 1'b0;
      flt_s2 <= 1'b0;
    end else begin
      sync_s1 <= pwm_sync;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      flt_s1 <= fault_pin;
      flt_s2 <= flt_s1;
    end
  end

  // ************************************************************
  // Delay counter and triggers
  // ************************************************************
  // Reloads never reach this input; only the period-start sync does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      running_q <= 1'b0;
      a_done_q <= 1'b0;
      b_done_q <= 1'b0;
    end else if (sync_rise) begin
      cnt_q <= '0;
      running_q <= 1'b1;
      a_done_q <= 1'b0;
      b_done_q <= 1'b0;
    end else if (running_q) begin
      cnt_q <= cnt_q + 16'h0001;
      running_q <= (cnt_q != DTB_CNT_MAX);
      a_done_q <= a_done_q | trig_a;
      b_done_q <= b_done_q | hit_b;
    end
  end

  // Second trigger waits for both converters; software should space
  // the delays so this wait is normally zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_pend_q <= 1'b0;
    end else if (sync_rise) begin
      b_pend_q <= 1'b0;
    end else begin
      b_pend_q <= (b_pend_q | hit_b) & ~launch_b;
    end
  end

  // ************************************************************
  // Converter commands and results
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv0_cmd <= '0;
      conv1_cmd <= '0;
      busy_q <= 2'b00;
      slot_q <= 2'b00;
    end else begin
      conv0_cmd <= '0;
      conv1_cmd <= '0;
      if (trig_a) begin
        conv0_cmd <= '{start: 1'b1, slot_b: 1'b0, chan: ctl_q[0].chan};
        conv1_cmd <= '{start: 1'b1, slot_b: 1'b1, chan: ctl_q[3].chan};
        busy_q <= 2'b11;
        slot_q <= 2'b10;
      end else if (launch_b) begin
        conv0_cmd <= '{start: 1'b1, slot_b: 1'b1, chan: ctl_q[1].chan};
        conv1_cmd <= '{start: 1'b1, slot_b: 1'b0, chan: ctl_q[2].chan};
        busy_q <= 2'b11;
        slot_q <= 2'b01;
      end else begin
        busy_q <= busy_q & ~{conv1_res.done, conv0_res.done};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        res_q[i] <= '0;
      end
    end else begin
      if (conv0_res.done) begin
        res_q[{1'b0, slot_q[0]}] <= conv0_res.data;
      end
      if (conv1_res.done) begin
        res_q[{1'b1, slot_q[1]}] <= conv1_res.data;
      end
    end
  end

  // Completion beats a same-cycle read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_q <= 2'b00;
    end else begin
      cc_q <= (cc_q & ~rd_res) | {conv1_res.done, conv0_res.done};
    end
  end

  // Converter clock enable at a quarter of the bus clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_div_q <= 2'b00;
      adc_clk_en <= 1'b0;
    end else begin
      adc_div_q <= (adc_div_q == DTB_ADC_DIV_LAST) ? 2'b00 : adc_div_q + 2'b01;
      adc_clk_en <= (adc_div_q == DTB_ADC_DIV_LAST);
    end
  end

  // ************************************************************
  // Fault filter
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_div_q <= 8'h00;
      agree_q <= 4'h0;
      fault_out <= 1'b0;
    end else if (flt_per_q == 8'h00) begin
      flt_div_q <= 8'h00;
      agree_q <= 4'h0;
      fault_out <= flt_s2;
    end else if (flt_div_q + 8'h01 >= flt_per_q) begin
      flt_div_q <= 8'h00;
      if (flt_s2 == fault_out) begin
        agree_q <= 4'h0;
      end else if (agree_q + 4'h1 >= flt_num_q) begin
        agree_q <= 4'h0;
        fault_out <= flt_s2;
      end else begin
        agree_q <= agree_q + 4'h1;
      end
    end else begin
      flt_div_q <= flt_div_q + 8'h01;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  logic fault_d1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_d1 <= 1'b0;
      stat_q <= '0;
      irq <= 1'b0;
    end else begin
      fault_d1 <= fault_out;
      stat_q <= (stat_q & ~((wr && paddr == DTB_OFF_IRQ_CLR) ?
                pwdata[DTB_IRQ_W-1:0] : 4'h0)) | ev |
                {2'b00, fault_out & ~fault_d1, 1'b0};
      irq <= |(stat_q & en_q);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sync;
    sync_rise;
  endsequence

  trig_a_match_a: assert property (conv0_cmd.start && !conv0_cmd.slot_b |->
    $past(cnt_q) == $past(delay_a_q)) else $error("first trigger off its delay");
  sync_restart_a: assert property (s_sync ##1 1'b1 |-> cnt_q == 16'h0000 && running_q)
    else $error("sync did not restart counter");
  one_a_per_a: assert property (trig_a |=> !trig_a ##1 ($past(sync_rise) || !trig_a))
    else $error("second first-trigger in one period");
  pair_start_a: assert property (conv0_cmd.start |-> conv1_cmd.start &&
    (conv0_cmd.slot_b != conv1_cmd.slot_b)) else $error("converters not started as pair");
  b_after_idle_a: assert property (launch_b |-> $past(busy_q) == 2'b00 ||
    $past(busy_q & ~{conv1_res.done, conv0_res.done}) == 2'b00) else $error("B busy");
  read_clear_a: assert property (rd_res[0] && !conv0_res.done |=> !cc_q[0])
    else $error("result read kept flag");
  filter_off_a: assert property (flt_per_q == 8'h00 && $stable(flt_per_q) |=>
    fault_out == $past(flt_s2)) else $error("filter off not transparent");
  conv_irq_a: assert property (conv0_res.done && !slot_q[0] && ctl_q[0].ie
    |=> stat_q[DTB_IRQ_CONV]) else $error("conversion interrupt missed");
  gain_block_a: assert property (ctrl_q[DTB_CTRL_GAIN_BIT] |=> !conv0_cmd.start ||
    $past(launch_b)) else $error("start with gain path on");
  adc_div_a: assert property (adc_clk_en |=> !adc_clk_en [*3] ##1 adc_clk_en)
    else $error("converter clock not divided by four");
endmodule

// ==== sim/dtb_conv_pair.sv ====
// Stand-in for the two converters behind the sequencer.
// Assumes starts and the converter clock pulse come from the sequencer.
`timescale 1ns/1ps
module dtb_conv_pair
  import dtb_pkg::*;
#(
  parameter int LAT0 = 3,
  parameter int LAT1 = 8
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sequencer side
  input wire dtb_pkg::dtb_cmd_type cmd0,
  input wire dtb_pkg::dtb_cmd_type cmd1,
  input wire logic adc_clk_en,
  output dtb_pkg::dtb_res_type res0,
  output dtb_pkg::dtb_res_type res1
);
  int left_q[2];
  logic [11:0] word_q[2];
  dtb_res_type res_q[2];
  dtb_cmd_type cmd_w[2];
  assign cmd_w[0] = cmd0;
  assign cmd_w[1] = cmd1;
  assign res0 = res_q[0];
  assign res1 = res_q[1];
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 2; i++) begin
      if (!presetn) begin
        left_q[i] <= 0;
        word_q[i] <= '0;
        res_q[i] <= '0;
      end else begin
        res_q[i].done <= 1'b0;
        // Data is not held outside the done pulse
        res_q[i].data <= ~res_q[i].data;
        if (cmd_w[i].start) begin
          left_q[i] <= (i == 0) ? LAT0 : LAT1;
          word_q[i] <= {1'b0, cmd_w[i].slot_b, cmd_w[i].chan, 5'h15} ^
                       ((i == 1) ? 12'hFFF : 12'h0);
        end else if (left_q[i] > 0 && adc_clk_en) begin
          // Conversion time counts converter clock ticks only
          left_q[i] <= left_q[i] - 1;
          if (left_q[i] == 1) begin
            res_q[i].done <= 1'b1;
            res_q[i].data <= word_q[i];
          end
        end
      end
    end
  end
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the delay trigger block.
// Assumes an APB master here and the converter pair model beside it.
`timescale 1ns/1ps
module tb;
  import dtb_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pwm_sync = 0, fault_pin = 0, err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, seed = 32'd97328;
  logic [4:0] ch[4];
  wire logic [31:0] prdata;
  wire logic pready, pslverr, fault_out, irq, adc_clk_en;
  dtb_cmd_type c0, c1;
  dtb_res_type r0, r1;
  int failures = 0, cmp_count = 0, cyc = 0, sync_cyc, done_cyc, lat, st0[$], st1[$];
  always #25 pclk = ~pclk;

  dtb_sequencer dtb_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_sync(pwm_sync), .fault_pin(fault_pin),
    .fault_out(fault_out), .irq(irq), .conv0_cmd(c0), .conv1_cmd(c1),
    .adc_clk_en(adc_clk_en), .conv0_res(r0), .conv1_res(r1));
  dtb_conv_pair dtb_conv_pair_i (.pclk(pclk), .presetn(presetn), .cmd0(c0), .cmd1(c1),
    .adc_clk_en(adc_clk_en), .res0(r0), .res1(r1));

  // ****************************************
  // Shared tasks
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Automatic: the trigger monitor and the main sequence may compare in one step
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task run(input int da, input int db, input logic [31:0] ctrl);
    apb(1'b1, DTB_OFF_DELAY_A, 32'(da));
    apb(1'b1, DTB_OFF_DELAY_B, 32'(db));
    apb(1'b1, DTB_OFF_CTRL, ctrl);
    st0 = {};
    st1 = {};
    @(posedge pclk);
    pwm_sync <= 1'b1;
    sync_cyc = cyc;
    repeat (3) @(posedge pclk);
    pwm_sync <= 1'b0;
    repeat (db + 200) @(posedge pclk);
  endtask

  // ****************************************
  // Trigger monitor
  // ****************************************
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (st0.size() == 1 && (r0.done === 1'b1 || r1.done === 1'b1)) done_cyc <= cyc;
    if (c0.start === 1'b1) begin
      chk("c0 cmd", st0.size() == 0 ? {26'h0, 1'b0, ch[0]} : {26'h0, 1'b1, ch[1]},
          32'({c0.slot_b, c0.chan}));
      st0.push_back(cyc);
    end
    if (c1.start === 1'b1) begin
      chk("c1 cmd", st1.size() == 0 ? {26'h0, 1'b1, ch[3]} : {26'h0, 1'b0, ch[2]},
          32'({c1.slot_b, c1.chan}));
      st1.push_back(cyc);
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    give_verdict;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(DTB_OFF_CTRL, 32'h0, "ctrl");
    rdc(DTB_OFF_DELAY_A, 32'h660, "delay_a");
    rdc(DTB_OFF_DELAY_B, 32'h6D6, "delay_b");
    rdc(DTB_OFF_FLT_CFG, 32'h300, "flt_cfg");
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      ch[i] = seed[4:0];
      apb(1'b1, DTB_OFF_CONV_CTL + 8'(4 * i), {25'h0, i == 0, 1'b0, ch[i]});
      rdc(DTB_OFF_CONV_CTL + 8'(4 * i), {25'h0, i == 0, 1'b0, ch[i]}, "conv_ctl");
    end
    $display("test registers done");
    apb(1'b1, DTB_OFF_IRQ_EN, 32'h1);
    // Gap shorter than a conversion: second pair waits for both done
    run(40, 50, 32'h1);
    chk("starts0", 32'h2, 32'(st0.size()));
    chk("starts1", 32'h2, 32'(st1.size()));
    // Done seen, busy clears, launch cycle, then the start pulse
    chk("b after done", 32'(done_cyc + 2), 32'(st0[1]));
    lat = st0[0] - sync_cyc - 40;
    apb(1'b0, DTB_OFF_STATUS, 32'h0);
    chk("cc both", 32'h3, 32'(rd[1:0]));
    for (int i = 0; i < 4; i++) begin
      // Results are serviced well before the next sync pulse
      rdc(DTB_OFF_CONV_RES + 8'(4 * i),
          32'({1'b0, i[0], ch[i], 5'h15} ^ (i > 1 ? 12'hFFF : 12'h0)), "result");
      if (i == 0) begin
        apb(1'b0, DTB_OFF_STATUS, 32'h0);
        chk("cc0 clear", 32'h2, 32'(rd[1:0]));
      end
    end
    chk("irq set", 32'h1, 32'(irq));
    apb(1'b1, DTB_OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, DTB_OFF_IRQ_EN, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq again", 32'h1, 32'(irq));
    apb(1'b1, DTB_OFF_IRQ_CLR, 32'hF);
    repeat (2) @(posedge pclk);
    chk("irq clear", 32'h0, 32'(irq));
    rdc(DTB_OFF_IRQ_STAT, 32'h0, "irq_stat");
    $display("test ping-pong done");
    run(30, 150, 32'h1);
    chk("gap", 32'd120, 32'(st0[1] - st0[0]));
    chk("lat", 32'(lat), 32'(st0[0] - sync_cyc - 30));
    chk("together", 32'(st0[0]), 32'(st1[0]));
    run(30, 150, 32'h3);
    chk("gain on", 32'h0, 32'(st0.size() + st1.size()));
    run(30, 150, 32'h0);
    chk("disabled", 32'h0, 32'(st0.size() + st1.size()));
    $display("test delays done");
    fault_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("flt off hi", 32'h1, 32'(fault_out));
    fault_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("flt off lo", 32'h0, 32'(fault_out));
    apb(1'b1, DTB_OFF_FLT_CFG, 32'h302);
    fault_pin <= 1'b1;
    @(posedge pclk);
    fault_pin <= 1'b0;
    repeat (30) @(posedge pclk);
    chk("glitch", 32'h0, 32'(fault_out));
    fault_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("flt early", 32'h0, 32'(fault_out));
    repeat (30) @(posedge pclk);
    chk("flt late", 32'h1, 32'(fault_out));
    $display("test filter done");
    give_verdict;
  end
endmodule
